/* core/smbchg_pkg.sv */
// Overview of operation
// - device is slave only, never drives SCL
// - slave address 7'h09, write byte 8'h12
// - bus ignored unless supply and adapter valid
// - START is SDA fall while SCL high
// - STOP is SDA rise, frees the bus
// - SDA changes only while SCL is low
// - bytes MSB first, sampled while SCL is high
// - nine clocks per byte, receiver acknowledges
// - word write and word read transactions
// - write word: device acks all four bytes
// - read word: repeated START, low then high
// - master acks low byte, nacks high, stops
// - direction bit 1 read; ack is low
// - commands 14, 15, 3F are readable settings
// - command 12 is the option word
// - FF part id, FE maker id, read
// - identification words are fixed, writes ignored
// - settings keep 7, 11, 6 significant bits
package smbchg_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h09;
  localparam logic [7:0] CMD_OPTION = 8'h12;
  localparam logic [7:0] CMD_CURRENT = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT = 8'h3F;
  localparam logic [7:0] CMD_MAKER = 8'hFE;
  localparam logic [7:0] CMD_PART = 8'hFF;
  localparam logic [15:0] OPTION_RESET = 16'hF902;
  localparam logic [15:0] CURRENT_RESET = 16'h0000;
  localparam logic [15:0] VOLTAGE_RESET = 16'h0000;
  localparam logic [15:0] INPUT_RESET = 16'h1000;
  localparam logic [15:0] CURRENT_MASK = 16'h1FC0;
  localparam logic [15:0] VOLTAGE_MASK = 16'h7FF0;
  localparam logic [15:0] INPUT_MASK = 16'h1F80;
  // arbitrary identification values
  localparam logic [15:0] MAKER_ID_VALUE = 16'h0A5A;
  localparam logic [15:0] PART_ID_VALUE = 16'h0C3C;
  localparam int MCLK_PERIOD_NS = 20;
  // fast link clock keeps runs short; raise it for a real bus
  localparam int SCL_PERIOD_NS = 1600;
  localparam logic [7:0] QUARTER_CYCLES = 8'(SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS));
  localparam logic [3:0] ITEM_RESTART = 4'h3;
  localparam logic [3:0] ITEM_STOP_WR = 4'h5;
  localparam logic [3:0] ITEM_RX_LO = 4'h5;
  localparam logic [3:0] ITEM_RX_HI = 4'h6;
  localparam logic [3:0] ITEM_STOP_RD = 4'h7;
  localparam logic [2:0] HREG_CMD = 3'h0;
  localparam logic [2:0] HREG_WDATA = 3'h1;
  localparam logic [2:0] HREG_CTRL = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_RDATA = 3'h4;
  localparam int CTRL_GO_WRITE_BIT = 0;
  localparam int CTRL_GO_READ_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_NACK_BIT = 1;
  typedef enum logic [2:0] {
    SMBCHG_K_START,
    SMBCHG_K_STOP,
    SMBCHG_K_TX,
    SMBCHG_K_RX_ACK,
    SMBCHG_K_RX_NACK
  } smbchg_kind_t;
endpackage

/* core/smbchg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface smbchg_if;
  logic scl_h_out;
  logic scl_h_oe;
  logic sda_h_out;
  logic sda_h_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // open-drain wired AND with pull-up
  assign scl = !(scl_h_oe && !scl_h_out);
  assign sda = !((sda_h_oe && !sda_h_out) || (sda_d_oe && !sda_d_out));
  modport host (output scl_h_out, scl_h_oe, sda_h_out, sda_h_oe, input scl, sda);
  modport dev (output sda_d_out, sda_d_oe, input scl, sda);
endinterface
`default_nettype wire

/* core/smbchg_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module smbchg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] q_prev
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } smbchg_sync_t;
  smbchg_sync_t s;
  smbchg_sync_t next_s;
  always_comb begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end
  // idle bus level is high, so reset to ones to avoid false edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end
  assign q = s.s2;
  assign q_prev = s.s3;
endmodule
`default_nettype wire

/* core/smbchg_host.sv */
`timescale 1ns/10ps
`default_nettype none
module smbchg_host (
  input wire logic mclk,
  input wire logic rst_n,
  smbchg_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  typedef enum logic {H_IDLE, H_RUN} smbchg_hst_t;
  typedef struct packed {
    smbchg_hst_t st;
    logic [3:0] item;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] div;
    logic [7:0] shreg;
    logic rd_mode;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rword;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic [15:0] rdata;
  } smbchg_host_t;
  smbchg_host_t s;
  smbchg_host_t next_s;
  logic sda_in;
  smbchg_pkg::smbchg_kind_t k;
  smbchg_pkg::smbchg_kind_t nk;

  smbchg_sync #(.WIDTH(1)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(bus.sda),
    .q(sda_in),
    .q_prev()
  );

  function automatic smbchg_pkg::smbchg_kind_t item_kind(input logic [3:0] it, input logic rd);
    item_kind = smbchg_pkg::SMBCHG_K_TX;
    if (it == 4'h0 || (rd && it == smbchg_pkg::ITEM_RESTART)) begin
      item_kind = smbchg_pkg::SMBCHG_K_START;
    end else if (it == (rd ? smbchg_pkg::ITEM_STOP_RD : smbchg_pkg::ITEM_STOP_WR)) begin
      item_kind = smbchg_pkg::SMBCHG_K_STOP;
    end else if (rd && it == smbchg_pkg::ITEM_RX_LO) begin
      item_kind = smbchg_pkg::SMBCHG_K_RX_ACK;
    end else if (rd && it == smbchg_pkg::ITEM_RX_HI) begin
      item_kind = smbchg_pkg::SMBCHG_K_RX_NACK;
    end
  endfunction

  function automatic logic [7:0] tx_byte(input smbchg_host_t h, input logic [3:0] it);
    unique case (it)
      4'h1: tx_byte = {smbchg_pkg::SLAVE_ADDR, 1'b0};
      4'h2: tx_byte = h.cmd;
      4'h3: tx_byte = h.wdata[7:0];
      4'h4: tx_byte = h.rd_mode ? {smbchg_pkg::SLAVE_ADDR, 1'b1} : h.wdata[15:8];
      default: tx_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    k = item_kind(s.item, s.rd_mode);
    nk = k;
    next_s.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        smbchg_pkg::HREG_CMD: next_s.rdata = {8'h00, s.cmd};
        smbchg_pkg::HREG_WDATA: next_s.rdata = s.wdata;
        smbchg_pkg::HREG_STATUS: next_s.rdata = {14'h0000, s.nack, s.st == H_RUN};
        smbchg_pkg::HREG_RDATA: next_s.rdata = s.rword;
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (reg_wr && s.st == H_IDLE) begin
      if (reg_addr == smbchg_pkg::HREG_CMD) begin
        next_s.cmd = reg_wdata[7:0];
      end else if (reg_addr == smbchg_pkg::HREG_WDATA) begin
        next_s.wdata = reg_wdata;
      end else if (reg_addr == smbchg_pkg::HREG_CTRL &&
                   (reg_wdata[smbchg_pkg::CTRL_GO_WRITE_BIT] ||
                    reg_wdata[smbchg_pkg::CTRL_GO_READ_BIT])) begin
        next_s.st = H_RUN;
        next_s.rd_mode = reg_wdata[smbchg_pkg::CTRL_GO_READ_BIT];
        next_s.nack = 1'b0;
        next_s.item = 4'h0;
        next_s.phase = 2'h0;
        next_s.bitn = 4'h0;
        next_s.div = 8'h00;
        next_s.scl_oe = 1'b1;
        next_s.sda_oe = 1'b0;
      end
    end
    if (s.st == H_RUN) begin
      next_s.div = s.div + 8'h01;
      if (s.div == smbchg_pkg::QUARTER_CYCLES - 8'h01) begin
        next_s.div = 8'h00;
        next_s.phase = s.phase + 2'h1;
        // sample at end of high phase, SCL still high
        if (s.phase == 2'h3) begin
          if ((k == smbchg_pkg::SMBCHG_K_RX_ACK || k == smbchg_pkg::SMBCHG_K_RX_NACK) &&
              s.bitn != 4'h8) begin
            next_s.shreg = {s.shreg[6:0], sda_in};
          end
          if (k == smbchg_pkg::SMBCHG_K_TX && s.bitn != 4'h8) begin
            next_s.shreg = {s.shreg[6:0], 1'b0};
          end
          if (k != smbchg_pkg::SMBCHG_K_START && k != smbchg_pkg::SMBCHG_K_STOP &&
              s.bitn != 4'h8) begin
            next_s.bitn = s.bitn + 4'h1;
          end else begin
            next_s.bitn = 4'h0;
            next_s.item = s.item + 4'h1;
            if (k == smbchg_pkg::SMBCHG_K_TX && sda_in) begin
              next_s.nack = 1'b1;
              next_s.item = s.rd_mode ? smbchg_pkg::ITEM_STOP_RD : smbchg_pkg::ITEM_STOP_WR;
            end
            if (k == smbchg_pkg::SMBCHG_K_RX_ACK) begin
              next_s.rword[7:0] = s.shreg;
            end
            if (k == smbchg_pkg::SMBCHG_K_RX_NACK) begin
              next_s.rword[15:8] = s.shreg;
            end
            if (k == smbchg_pkg::SMBCHG_K_STOP) begin
              next_s.st = H_IDLE;
            end
            next_s.shreg = tx_byte(s, next_s.item);
          end
        end
        nk = item_kind(next_s.item, s.rd_mode);
        unique case (nk)
          smbchg_pkg::SMBCHG_K_START: begin
            next_s.scl_oe = next_s.phase == 2'h0 || next_s.phase == 2'h3;
            next_s.sda_oe = next_s.phase[1];
          end
          smbchg_pkg::SMBCHG_K_STOP: begin
            next_s.scl_oe = next_s.phase == 2'h0;
            next_s.sda_oe = !next_s.phase[1];
          end
          smbchg_pkg::SMBCHG_K_TX: begin
            next_s.scl_oe = !next_s.phase[1];
            next_s.sda_oe = next_s.bitn != 4'h8 && !next_s.shreg[7];
          end
          smbchg_pkg::SMBCHG_K_RX_ACK: begin
            next_s.scl_oe = !next_s.phase[1];
            next_s.sda_oe = next_s.bitn == 4'h8;
          end
          smbchg_pkg::SMBCHG_K_RX_NACK: begin
            next_s.scl_oe = !next_s.phase[1];
            next_s.sda_oe = 1'b0;
          end
        endcase
        if (next_s.st == H_IDLE) begin
          next_s.scl_oe = 1'b0;
          next_s.sda_oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.scl_h_out = 1'b0;
  assign bus.sda_h_out = 1'b0;
  assign bus.scl_h_oe = s.scl_oe;
  assign bus.sda_h_oe = s.sda_oe;
  assign reg_rdata = s.rdata;
endmodule
`default_nettype wire

/* core/smbchg_dev.sv */
`timescale 1ns/10ps
`default_nettype none
module smbchg_dev (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic vcc_above_undervoltage_lockout,
  input wire logic adapter_detect_input,
  smbchg_if.dev bus,
  output logic [15:0] charger_option_word,
  output logic [15:0] charge_current_setting,
  output logic [15:0] charge_voltage_setting,
  output logic [15:0] input_current_limit_setting,
  output logic word_written,
  output logic [7:0] word_written_cmd,
  output logic comm_enabled
);
  typedef enum logic [2:0] {D_IDLE, D_RX, D_RXACK, D_TX, D_TXACK} smbchg_dst_t;
  typedef struct packed {
    smbchg_dst_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [2:0] byte_idx;
    logic rd_mode;
    logic [7:0] cmd;
    logic [7:0] lo;
    logic mack;
    logic hi_sent;
    logic sda_oe;
    logic wr_pulse;
    logic [7:0] wr_cmd;
    logic en;
    logic [15:0] option;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] input_lim;
  } smbchg_dev_t;
  smbchg_dev_t s;
  smbchg_dev_t next_s;
  logic [3:0] q;
  logic [3:0] qp;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic en;
  logic sda_in;
  logic [15:0] word;

  // bit 3 scl, bit 2 sda, bit 1 supply, bit 0 adapter
  smbchg_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({bus.scl, bus.sda, vcc_above_undervoltage_lockout, adapter_detect_input}),
    .q(q),
    .q_prev(qp)
  );

  assign sda_in = q[2];
  assign scl_rise = q[3] && !qp[3];
  assign scl_fall = !q[3] && qp[3];
  // both lines pass the same stages, so their order is kept
  assign start_seen = q[3] && qp[3] && qp[2] && !q[2];
  assign stop_seen = q[3] && qp[3] && !qp[2] && q[2];
  assign en = q[1] && q[0];

  function automatic logic [15:0] read_word(input smbchg_dev_t d);
    unique case (d.cmd)
      smbchg_pkg::CMD_OPTION: read_word = d.option;
      smbchg_pkg::CMD_CURRENT: read_word = d.current;
      smbchg_pkg::CMD_VOLTAGE: read_word = d.voltage;
      smbchg_pkg::CMD_INPUT: read_word = d.input_lim;
      smbchg_pkg::CMD_MAKER: read_word = smbchg_pkg::MAKER_ID_VALUE;
      smbchg_pkg::CMD_PART: read_word = smbchg_pkg::PART_ID_VALUE;
      default: read_word = 16'h0000;
    endcase
  endfunction

  assign word = read_word(s);

  always_comb begin
    next_s = s;
    next_s.wr_pulse = 1'b0;
    next_s.en = en;
    if (!en) begin
      next_s.st = D_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (start_seen) begin
      // repeated START keeps the command byte for the read phase
      next_s.st = D_RX;
      next_s.bitcnt = 4'h0;
      next_s.byte_idx = 3'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      // short write ends here, nothing committed
      next_s.st = D_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        D_IDLE: begin
          // only bus edges from the master move this machine
          next_s.sda_oe = 1'b0;
        end
        D_RX: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda_in};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            next_s.st = D_RXACK;
            next_s.sda_oe = 1'b1;
            next_s.byte_idx = s.byte_idx + 3'h1;
            unique case (s.byte_idx)
              3'h0: begin
                if (s.shreg[7:1] == smbchg_pkg::SLAVE_ADDR) begin
                  next_s.rd_mode = s.shreg[0];
                end else begin
                  next_s.st = D_IDLE;
                  next_s.sda_oe = 1'b0;
                end
              end
              3'h1: begin
                next_s.cmd = s.shreg;
              end
              3'h2: begin
                next_s.lo = s.shreg;
              end
              3'h3: begin
                next_s.wr_pulse = 1'b1;
                next_s.wr_cmd = s.cmd;
                unique case (s.cmd)
                  smbchg_pkg::CMD_OPTION: begin
                    next_s.option = {s.shreg, s.lo};
                  end
                  smbchg_pkg::CMD_CURRENT: begin
                    next_s.current = {s.shreg, s.lo} & smbchg_pkg::CURRENT_MASK;
                  end
                  smbchg_pkg::CMD_VOLTAGE: begin
                    next_s.voltage = {s.shreg, s.lo} & smbchg_pkg::VOLTAGE_MASK;
                  end
                  smbchg_pkg::CMD_INPUT: begin
                    next_s.input_lim = {s.shreg, s.lo} & smbchg_pkg::INPUT_MASK;
                  end
                  default: begin
                    next_s.wr_pulse = 1'b0;
                  end
                endcase
              end
              default: begin
                // bytes past the word are refused
                next_s.st = D_IDLE;
                next_s.sda_oe = 1'b0;
                next_s.byte_idx = s.byte_idx;
              end
            endcase
          end
        end
        D_RXACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.bitcnt = 4'h0;
            if (s.rd_mode) begin
              next_s.st = D_TX;
              next_s.shreg = word[7:0];
              next_s.hi_sent = 1'b0;
              next_s.sda_oe = !word[7];
            end else if (s.byte_idx == 3'h4) begin
              next_s.st = D_IDLE;
            end else begin
              next_s.st = D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (s.bitcnt == 4'h7) begin
              next_s.sda_oe = 1'b0;
              next_s.st = D_TXACK;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.bitcnt = s.bitcnt + 4'h1;
              next_s.sda_oe = !s.shreg[6];
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) begin
            next_s.mack = !sda_in;
          end else if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.mack && !s.hi_sent) begin
              next_s.st = D_TX;
              next_s.shreg = word[15:8];
              next_s.hi_sent = 1'b1;
              next_s.sda_oe = !word[15];
            end else begin
              next_s.st = D_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
      s.option <= smbchg_pkg::OPTION_RESET;
      s.current <= smbchg_pkg::CURRENT_RESET;
      s.voltage <= smbchg_pkg::VOLTAGE_RESET;
      s.input_lim <= smbchg_pkg::INPUT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // open drain: only ever pulls SDA low, SCL is never driven
  assign bus.sda_d_out = 1'b0;
  assign bus.sda_d_oe = s.sda_oe;
  assign charger_option_word = s.option;
  assign charge_current_setting = s.current;
  assign charge_voltage_setting = s.voltage;
  assign input_current_limit_setting = s.input_lim;
  assign word_written = s.wr_pulse;
  assign word_written_cmd = s.wr_cmd;
  assign comm_enabled = s.en;
endmodule
`default_nettype wire

/* verif/smbchg_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module smbchg_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_h_out,
  input wire logic scl_h_oe,
  input wire logic sda_h_out,
  input wire logic sda_h_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_scl_host_only: assert property (!scl |-> scl_h_oe && !scl_h_out)
    else $error("scl low without host pull");
  chk_dev_open_drain: assert property (sda_d_oe |-> !sda_d_out && !sda)
    else $error("device sda drive not low");
  chk_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("device sda moved while scl high");
  // device reacts to the synced fall, so scl is already low for some cycles
  chk_dev_drive_late: assert property ($rose(sda_d_oe) |-> !scl && !$past(scl, 2))
    else $error("device drive too close to scl fall");
  chk_start_by_host: assert property (scl && $past(scl) && $fell(sda)
    |-> !sda_d_oe && !$past(sda_d_oe))
    else $error("start caused by device");
  chk_stop_by_host: assert property (scl && $past(scl) && $rose(sda)
    |-> !$past(sda_d_oe))
    else $error("stop caused by device");
  chk_dev_ack_hold: assert property ($rose(scl) && sda_d_oe |-> sda_d_oe [*8])
    else $error("device drive dropped in high phase");
  chk_scl_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  chk_scl_low_span: assert property ($fell(scl) |=> !scl [*8])
    else $error("scl low phase too short");
  cover property ($rose(sda_d_oe));
  cover property (scl && $past(scl) && $fell(sda));
  cover property (scl && $past(scl) && $rose(sda));
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] go;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [15:0] exp;
  } smbchg_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic vcc_ok = 1'b1;
  logic adapter_ok = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, opt, cur, vol, inl, st, rd;
  logic word_written, comm_enabled;
  logic [7:0] word_written_cmd;
  int err_total = 0;
  int tests_run = 0;
  int ww_cnt = 0;
  int stop_cnt = 0;
  int bit_cnt = 0;
  int w0, s0;
  logic [8:0] shift9 = 9'h000;
  logic [8:0] head9 = 9'h000;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  smbchg_row_t rows [10];
  smbchg_if bus_if ();
  smbchg_host smbchg_host_i (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  smbchg_dev smbchg_dev_i (.mclk(mclk), .rst_n(rst_n),
    .vcc_above_undervoltage_lockout(vcc_ok), .adapter_detect_input(adapter_ok),
    .bus(bus_if), .charger_option_word(opt), .charge_current_setting(cur),
    .charge_voltage_setting(vol), .input_current_limit_setting(inl),
    .word_written(word_written), .word_written_cmd(word_written_cmd),
    .comm_enabled(comm_enabled));
  smbchg_checker smbchg_checker_i (.mclk(mclk), .rst_n(rst_n),
    .scl_h_out(bus_if.scl_h_out), .scl_h_oe(bus_if.scl_h_oe),
    .sda_h_out(bus_if.sda_h_out), .sda_h_oe(bus_if.sda_h_oe),
    .sda_d_out(bus_if.sda_d_out), .sda_d_oe(bus_if.sda_d_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // wire monitor: first nine bits after each start, stop count
  always @(posedge mclk) begin
    scl_q <= bus_if.scl;
    sda_q <= bus_if.sda;
    if (word_written === 1'b1) ww_cnt++;
    if (bus_if.scl && scl_q && sda_q && !bus_if.sda) bit_cnt = 0;
    if (bus_if.scl && scl_q && !sda_q && bus_if.sda) stop_cnt++;
    if (bus_if.scl && !scl_q) begin
      shift9 = {shift9[7:0], bus_if.sda};
      bit_cnt++;
      if (bit_cnt == 9) head9 = shift9;
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic xfer(input logic [1:0] go, input logic [7:0] cmd, input logic [15:0] wd);
    int n;
    w0 = ww_cnt;
    s0 = stop_cnt;
    reg_write(smbchg_pkg::HREG_CMD, {8'h00, cmd});
    reg_write(smbchg_pkg::HREG_WDATA, wd);
    reg_write(smbchg_pkg::HREG_CTRL, {14'h0000, go});
    n = 0;
    st = 16'h0001;
    // a read word is 48 link bits, about 2000 polls at this rate
    while (st[smbchg_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 4000) begin
      reg_read(smbchg_pkg::HREG_STATUS, st);
      n++;
    end
    if (n >= 4000) begin
      err_total++;
      give_verdict();
    end
    reg_read(smbchg_pkg::HREG_RDATA, rd);
    repeat (4) @(posedge mclk);
  endtask
  function automatic logic [15:0] pick(input logic [7:0] c);
    case (c)
      smbchg_pkg::CMD_OPTION: return opt;
      smbchg_pkg::CMD_CURRENT: return cur;
      smbchg_pkg::CMD_VOLTAGE: return vol;
      smbchg_pkg::CMD_INPUT: return inl;
      default: return 16'h0000;
    endcase
  endfunction
  initial begin
    // about 600 link bits of 80 cycles expected, with margin
    repeat (80000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
  initial begin
    rows[0] = '{2'h1, smbchg_pkg::CMD_OPTION, 16'hA5C3, 16'hA5C3};
    rows[1] = '{2'h1, smbchg_pkg::CMD_CURRENT, 16'hFFFF, 16'h1FC0};
    rows[2] = '{2'h1, smbchg_pkg::CMD_VOLTAGE, 16'hFFFF, 16'h7FF0};
    rows[3] = '{2'h1, smbchg_pkg::CMD_INPUT, 16'hFFFF, 16'h1F80};
    rows[4] = '{2'h2, smbchg_pkg::CMD_CURRENT, 16'h0000, 16'h1FC0};
    rows[5] = '{2'h2, smbchg_pkg::CMD_MAKER, 16'h0000, smbchg_pkg::MAKER_ID_VALUE};
    rows[6] = '{2'h2, smbchg_pkg::CMD_PART, 16'h0000, smbchg_pkg::PART_ID_VALUE};
    rows[7] = '{2'h2, smbchg_pkg::CMD_OPTION, 16'h0000, 16'hA5C3};
    rows[8] = '{2'h2, smbchg_pkg::CMD_VOLTAGE, 16'h0000, 16'h7FF0};
    rows[9] = '{2'h2, smbchg_pkg::CMD_INPUT, 16'h0000, 16'h1F80};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check("option reset", opt, smbchg_pkg::OPTION_RESET);
    check("current reset", cur, smbchg_pkg::CURRENT_RESET);
    check("voltage reset", vol, smbchg_pkg::VOLTAGE_RESET);
    check("input reset", inl, smbchg_pkg::INPUT_RESET);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      xfer(rows[i].go, rows[i].cmd, rows[i].wdata);
      check("status", st, 16'h0000);
      check("stops", 16'(stop_cnt - s0), 16'h0001);
      if (rows[i].go == 2'h1) begin
        check("word", pick(rows[i].cmd), rows[i].exp);
        check("commits", 16'(ww_cnt - w0), 16'h0001);
        check("commit cmd", {8'h00, word_written_cmd}, {8'h00, rows[i].cmd});
        check("head", {7'h00, head9}, {7'h00, smbchg_pkg::SLAVE_ADDR, 2'b00});
      end else begin
        check("read", rd, rows[i].exp);
        check("head", {7'h00, head9}, {7'h00, smbchg_pkg::SLAVE_ADDR, 2'b10});
      end
      $display("row %0d done", i);
    end
    // identification write and unknown command must both leave settings alone
    for (int j = 0; j < 2; j++) begin
      xfer(2'h1, (j == 0) ? smbchg_pkg::CMD_MAKER : 8'h13, 16'h1111);
      check("ignored commits", 16'(ww_cnt - w0), 16'h0000);
      check("option kept", opt, 16'hA5C3);
      check("current kept", cur, 16'h1FC0);
    end
    $display("ignored write test done");
    // first the adapter input, then the supply input drops
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        adapter_ok <= 1'b0;
      end else begin
        vcc_ok <= 1'b0;
      end
      repeat (10) @(posedge mclk);
      check("comm off", {15'h0000, comm_enabled}, 16'h0000);
      xfer(2'h1, smbchg_pkg::CMD_CURRENT, 16'h0000);
      check("nack", st, 16'h0002);
      check("current held", cur, 16'h1FC0);
      adapter_ok <= 1'b1;
      vcc_ok <= 1'b1;
      repeat (10) @(posedge mclk);
      check("comm on", {15'h0000, comm_enabled}, 16'h0001);
    end
    $display("disabled test done");
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check("option rerun", opt, smbchg_pkg::OPTION_RESET);
    check("current rerun", cur, smbchg_pkg::CURRENT_RESET);
    xfer(2'h2, smbchg_pkg::CMD_OPTION, 16'h0000);
    check("option reread", rd, smbchg_pkg::OPTION_RESET);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
